// file: gcd_bitdet.sv
// sub-bit shift register, code match and bit synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "gcd_defines.svh"
module gcd_bitdet (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clear,
   input  wire logic sub_en,
   input  wire logic sub_val,
   input  wire logic post_addr,
   output logic      bit_stb,
   output logic      bit_val,
   output logic      timing_err
);
   logic [4:0] shift_reg;   // last five sub-bits
   logic [4:0] shift_next;
   logic [2:0] cnt_reg;     // sub-bit position in bit
   logic       sync_reg;    // bit boundary known
   logic       is_one;
   logic       is_zero;

   // codes change once the vehicle address matched
   assign shift_next = {shift_reg[3:0], sub_val};
   assign is_one  = shift_next == (post_addr ? `GCD_POST_ONE : `GCD_PRE_ONE);
   assign is_zero = shift_next == (post_addr ? `GCD_POST_ZERO : `GCD_PRE_ZERO);

   // one bit per group of five sub-bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg  <= '0;
         cnt_reg    <= '0;
         sync_reg   <= 1'b0;
         bit_stb    <= 1'b0;
         bit_val    <= 1'b0;
         timing_err <= 1'b0;
      end else begin
         bit_stb    <= 1'b0;
         timing_err <= 1'b0;
         if (clear) begin
            shift_reg <= '0;
            cnt_reg   <= '0;
            sync_reg  <= 1'b0;
         end else if (sub_en) begin
            shift_reg <= shift_next;
            if (!sync_reg) begin
               // hunting: slide until a valid code appears
               if (is_one || is_zero) begin
                  sync_reg <= 1'b1;
                  cnt_reg  <= '0;
                  bit_stb  <= 1'b1;
                  bit_val  <= is_one;
               end
            end else if (cnt_reg == 3'(`GCD_SUBBITS - 1)) begin
               // group boundary: code must be valid
               cnt_reg <= '0;
               if (is_one || is_zero) begin
                  bit_stb <= 1'b1;
                  bit_val <= is_one;
               end else begin
                  timing_err <= 1'b1;
                  sync_reg   <= 1'b0;
               end
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: gcd_decoder.sv
// ground command decoder top: uplink bits to latching relays
`timescale 1ns/10ps
`default_nettype none
`include "gcd_defines.svh"

// Notes on behaviour
// - a message is exactly twelve bits
// - five sub-bits code each bit
// - first three bits are vehicle address
// - bits four to six select real-time command
// - last six: relay number plus set flag
// - in phase is one, inverted is zero
// - either redundant receiver alone suffices
// - three units of eight latching relays
// - immediate channels act on receipt
// - deferred channels wait for pulse bus
// - fixed per-channel deferred attribute
// - relay states visible to telemetry
// - new sub-bit codes after vehicle match
// - reset after transfer or 100 ms timeout
// - reset on timing error or power fault
module gcd_decoder
   import gcd_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `GCD_TIMEOUT_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        RX_A_INFO,
   input  wire logic        RX_A_REF,
   input  wire logic        RX_A_OK,
   input  wire logic        RX_B_INFO,
   input  wire logic        RX_B_REF,
   input  wire logic        RX_B_OK,
   input  wire logic        PWR_FAULT,
   input  wire logic        RELAY_READY,
   output logic [23:0]      RELAY_STATE,
   output logic [23:0]      EQUIP_ON,
   output logic             PULSE_BUS,
   output logic             CMD_VERIFY,
   output logic             MSG_ABORT,
   output logic             CMD_PENDING
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   gcd_state_t                 state_reg;     // message assembly state
   gcd_state_t                 state_next;
   logic [`GCD_DIV_W-1:0]      div_reg;       // sub-bit rate divider
   logic                       sub_en_reg;    // one pulse per sub-bit
   logic                       sub_val_reg;   // sampled sub-bit
   logic                       phase_a;       // receiver a sub-bit
   logic                       phase_b;       // receiver b sub-bit
   logic [3:0]                 bits_reg;      // bits received so far
   logic [`GCD_MSG_BITS-1:0]   msg_reg;       // message shift register
   logic [`GCD_MSG_BITS-1:0]   msg_next;
   logic [`GCD_TMO_W-1:0]      tmo_reg;       // transfer wait timer
   logic                       clear_reg;     // restart bit detector
   logic                       post_addr;     // vehicle matched
   logic                       bit_stb;       // new bit from detector
   logic                       bit_val;       // its value
   logic                       timing_err;    // bad group boundary
   logic                       abort;         // drop current message
   logic                       tmo_hit;       // wait exceeded
   logic                       fifo_in_valid; // command offered
   logic                       fifo_in_ready; // room for command
   logic                       fifo_out_valid;
   logic                       fifo_out_ready;
   logic [`GCD_CMD_W-1:0]      fifo_out_data;
   logic [4:0]                 cmd_chan;      // relay number, 1 based
   logic                       cmd_set;       // set or reset
   logic [4:0]                 cmd_idx;       // relay index, 0 based
   logic                       cmd_exec;      // execute channel
   logic                       cmd_known;     // channel exists
   localparam logic [`GCD_RELAYS-1:0] defer_mask = `GCD_DEFER_MASK;

   // ----------------------------------------------------------------------
   // receiver combining and sub-bit timing
   // ----------------------------------------------------------------------

   // phase compare: in phase with reference reads one
   assign phase_a = ~(RX_A_INFO ^ RX_A_REF);
   assign phase_b = ~(RX_B_INFO ^ RX_B_REF);

   // divider gives one enable per sub-bit period
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_reg    <= '0;
         sub_en_reg <= 1'b0;
      end else begin
         if (div_reg == `GCD_DIV_W'(`GCD_SUBBIT_CYC - 1)) begin
            div_reg    <= '0;
            sub_en_reg <= 1'b1;
         end else begin
            div_reg    <= div_reg + 1'b1;
            sub_en_reg <= 1'b0;
         end
      end
   end

   // sample from whichever receiver is healthy
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sub_val_reg <= 1'b0;
      end else if (div_reg == `GCD_DIV_W'(`GCD_SUBBIT_CYC - 1)) begin
         if (RX_A_OK) begin
            sub_val_reg <= phase_a;
         end else if (RX_B_OK) begin
            sub_val_reg <= phase_b;
         end else begin
            sub_val_reg <= phase_a;   // neither healthy: noise
         end
      end
   end

   // ----------------------------------------------------------------------
   // bit detection
   // ----------------------------------------------------------------------

   assign post_addr = (state_reg == GCD_BODY);

   gcd_bitdet u_bitdet (
      .clk        (CLK),
      .rst_n      (RST_B),
      .clear      (clear_reg),
      .sub_en     (sub_en_reg),
      .sub_val    (sub_val_reg),
      .post_addr  (post_addr),
      .bit_stb    (bit_stb),
      .bit_val    (bit_val),
      .timing_err (timing_err)
   );

   // ----------------------------------------------------------------------
   // message assembly
   // ----------------------------------------------------------------------

   // first bit received lands at the top after twelve shifts
   assign msg_next = {msg_reg[`GCD_MSG_BITS-2:0], bit_val};

   // transfer wait limit
   assign tmo_hit = (tmo_reg == `GCD_TMO_W'(TIMEOUT_CYCLES - 1));

   // reasons to throw the message away
   always_comb begin
      abort = 1'b0;
      if (PWR_FAULT || timing_err) begin
         abort = 1'b1;
      end else if (state_reg == GCD_PUSH && !fifo_in_ready && tmo_hit) begin
         abort = 1'b1;
      end
   end

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         GCD_HUNT: begin
            // third bit completes the vehicle address
            if (bit_stb && bits_reg == 4'(`GCD_VEH_BITS - 1)) begin
               if (msg_next[`GCD_VEH_BITS-1:0] == `GCD_VEH_ADDR) begin
                  state_next = GCD_BODY;
               end else begin
                  state_next = GCD_HUNT;
               end
            end
         end
         GCD_BODY: begin
            if (bit_stb && bits_reg == 4'(`GCD_SYS_END - 1) &&
                msg_next[2:0] != `GCD_SYS_RTC) begin
               state_next = GCD_HUNT;
            end else if (bit_stb && bits_reg == 4'(`GCD_MSG_BITS - 1)) begin
               state_next = GCD_PUSH;
            end
         end
         GCD_PUSH: begin
            if (fifo_in_ready) begin
               state_next = GCD_HUNT;
            end
         end
         default: begin
            state_next = GCD_HUNT;
         end
      endcase
      if (abort) begin
         state_next = GCD_HUNT;
      end
   end

   // state register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= GCD_HUNT;
      end else begin
         state_reg <= state_next;
      end
   end

   // bit count and message shift register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         bits_reg <= '0;
         msg_reg  <= '0;
      end else if (state_next == GCD_HUNT && state_reg != GCD_HUNT) begin
         bits_reg <= '0;
         msg_reg  <= '0;
      end else if (state_reg == GCD_HUNT && state_next == GCD_HUNT &&
                   bit_stb && bits_reg == 4'(`GCD_VEH_BITS - 1)) begin
         bits_reg <= '0;   // wrong vehicle, start over
         msg_reg  <= '0;
      end else if (abort) begin
         bits_reg <= '0;
         msg_reg  <= '0;
      end else if (bit_stb && state_reg != GCD_PUSH) begin
         bits_reg <= bits_reg + 1'b1;
         msg_reg  <= msg_next;
      end
   end

   // restart the bit detector whenever a message is dropped or done
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         clear_reg <= 1'b1;
      end else begin
         clear_reg <= (state_next == GCD_HUNT) &&
                      ((state_reg != GCD_HUNT) || abort ||
                       (bit_stb && bits_reg == 4'(`GCD_VEH_BITS - 1)));
      end
   end

   // transfer wait timer
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tmo_reg <= '0;
      end else if (state_reg == GCD_PUSH && !fifo_in_ready) begin
         tmo_reg <= tmo_reg + 1'b1;
      end else begin
         tmo_reg <= '0;
      end
   end

   // abort flag for telemetry
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         MSG_ABORT <= 1'b0;
      end else begin
         MSG_ABORT <= abort && (state_reg != GCD_HUNT || bits_reg != '0);
      end
   end

   // ----------------------------------------------------------------------
   // command buffer
   // ----------------------------------------------------------------------

   assign fifo_in_valid  = (state_reg == GCD_PUSH) && !abort;
   assign fifo_out_ready = RELAY_READY;

   // relay number and set flag, the last six bits
   gcd_fifo #(
      .WIDTH (`GCD_CMD_W),
      .DEPTH (`GCD_FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rst_n     (RST_B),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (msg_reg[`GCD_CMD_W-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ----------------------------------------------------------------------
   // relay driver
   // ----------------------------------------------------------------------

   // relay number in the upper five bits, set flag last
   assign cmd_chan  = fifo_out_data[5:1];
   assign cmd_set   = fifo_out_data[0];
   assign cmd_idx   = cmd_chan - 5'h01;
   assign cmd_exec  = (cmd_chan == `GCD_EXEC_CH_A) || (cmd_chan == `GCD_EXEC_CH_B);
   assign cmd_known = (cmd_chan != 5'h00) && (cmd_chan <= 5'(`GCD_RELAYS));

   // latching relays: after RST_B clears them, only a command moves them
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         RELAY_STATE <= '0;   // power-up state only
      end else if (fifo_out_valid && RELAY_READY && cmd_known) begin
         RELAY_STATE[cmd_idx] <= cmd_set;
      end
   end

   // equipment power: immediate now, deferred on pulse bus
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         EQUIP_ON <= '0;
      end else begin
         for (int i = 0; i < `GCD_RELAYS; i++) begin
            if (defer_mask[i]) begin
               if (PULSE_BUS) begin
                  EQUIP_ON[i] <= RELAY_STATE[i];
               end
            end else if (fifo_out_valid && RELAY_READY && cmd_known &&
                         cmd_idx == 5'(i)) begin
               EQUIP_ON[i] <= cmd_set;
            end
         end
      end
   end

   // execute channels energise the pulse bus for one cycle
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PULSE_BUS <= 1'b0;
      end else begin
         PULSE_BUS <= fifo_out_valid && RELAY_READY && cmd_exec;
      end
   end

   // verification pulse for telemetry on each applied command
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CMD_VERIFY <= 1'b0;
      end else begin
         CMD_VERIFY <= fifo_out_valid && RELAY_READY && cmd_known;
      end
   end

   // commands waiting for the relay side
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CMD_PENDING <= 1'b0;
      end else begin
         CMD_PENDING <= fifo_out_valid;
      end
   end

endmodule
`default_nettype wire

// file: gcd_decoder_asserts.sv
// port assertions for the ground command decoder
`timescale 1ns/10ps
`default_nettype none
`include "gcd_defines.svh"
module gcd_decoder_asserts #(
   parameter int TIMEOUT_CYCLES = 50
) (
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        RX_A_INFO,
   input wire logic        RX_A_REF,
   input wire logic        RX_A_OK,
   input wire logic        RX_B_INFO,
   input wire logic        RX_B_REF,
   input wire logic        RX_B_OK,
   input wire logic        PWR_FAULT,
   input wire logic        RELAY_READY,
   input wire logic [23:0] RELAY_STATE,
   input wire logic [23:0] EQUIP_ON,
   input wire logic        PULSE_BUS,
   input wire logic        CMD_VERIFY,
   input wire logic        MSG_ABORT,
   input wire logic        CMD_PENDING
);
   // ----------------------------------------------------------------
   // relations between outputs and their causes
   // ----------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   relay_cause_a: assert property ($changed(RELAY_STATE) |-> CMD_VERIFY)
      else $error("relay moved without a command");
   one_relay_a: assert property (CMD_VERIFY |-> $onehot0(RELAY_STATE ^ $past(RELAY_STATE)))
      else $error("command moved more than one relay");
   abort_pulse_a: assert property (MSG_ABORT |=> !MSG_ABORT)
      else $error("abort longer than one cycle");
   exec_verify_a: assert property (PULSE_BUS |-> CMD_VERIFY)
      else $error("pulse bus without applied command");
   defer_copy_a: assert property (PULSE_BUS |=>
      (((EQUIP_ON ^ $past(RELAY_STATE)) & `GCD_DEFER_MASK) == 24'h00_0000))
      else $error("deferred power not copied after pulse");
   defer_hold_a: assert property (
      (((EQUIP_ON ^ $past(EQUIP_ON)) & `GCD_DEFER_MASK) != 24'h00_0000) |-> $past(PULSE_BUS))
      else $error("deferred power moved without pulse");
   immed_follow_a: assert property (
      ((EQUIP_ON ^ RELAY_STATE) & ~`GCD_DEFER_MASK) == 24'h00_0000)
      else $error("immediate power differs from relay");
   ready_gate_a: assert property (CMD_VERIFY |-> $past(RELAY_READY))
      else $error("command applied while relay side not ready");
   // ----------------------------------------------------------------
   // main scenarios reached
   // ----------------------------------------------------------------
   verify_c: cover property (CMD_VERIFY);
   pulse_c: cover property (PULSE_BUS);
   abort_c: cover property (MSG_ABORT && !RELAY_READY);
endmodule
bind gcd_decoder gcd_decoder_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) gcd_decoder_asserts_i (
   .CLK(CLK), .RST_B(RST_B), .RX_A_INFO(RX_A_INFO), .RX_A_REF(RX_A_REF),
   .RX_A_OK(RX_A_OK), .RX_B_INFO(RX_B_INFO), .RX_B_REF(RX_B_REF), .RX_B_OK(RX_B_OK),
   .PWR_FAULT(PWR_FAULT), .RELAY_READY(RELAY_READY), .RELAY_STATE(RELAY_STATE),
   .EQUIP_ON(EQUIP_ON), .PULSE_BUS(PULSE_BUS), .CMD_VERIFY(CMD_VERIFY),
   .MSG_ABORT(MSG_ABORT), .CMD_PENDING(CMD_PENDING));
`default_nettype wire

// file: gcd_decoder_tb_top.sv
// self-checking bench for the ground command decoder
`timescale 1ns/10ps
`default_nettype none
`include "gcd_defines.svh"
module gcd_decoder_tb_top;
   typedef struct {logic abt; logic [23:0] rs;} gcd_note_t;
   localparam logic [23:0] DMASK = `GCD_DEFER_MASK;
   logic        CLK = 1'b0, RST_B = 1'b0, pwr = 1'b0, rdy = 1'b1, a_ok = 1'b1, b_ok = 1'b0;
   logic        a_i, a_r, b_i, b_r, vfy, pb, abt, pend;
   logic [23:0] rs, eq, exp_rs = 24'h00_0000, exp_eq = 24'h00_0000;
   logic [31:0] seed = 32'h895f_ca5b;
   logic [4:0]  rc;
   int          fail_count = 0, num_checks = 0, cyc = 0;
   gcd_note_t   notes[$];
   // ----------------------------------------------------------------
   // clock, random source, run limit
   // ----------------------------------------------------------------
   always #50 CLK = ~CLK;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always @(posedge CLK) begin
      seed <= lfsr(seed);
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         fail_count++;
         close_out();
      end
   end
   gcd_uplink gcd_uplink_i (.clk(CLK), .rst_n(RST_B), .a_ok(a_ok), .rnd(seed[0]),
      .a_info(a_i), .a_ref(a_r), .b_info(b_i), .b_ref(b_r));
   gcd_decoder #(.TIMEOUT_CYCLES(50)) gcd_decoder_i (.CLK(CLK), .RST_B(RST_B),
      .RX_A_INFO(a_i), .RX_A_REF(a_r), .RX_A_OK(a_ok), .RX_B_INFO(b_i), .RX_B_REF(b_r),
      .RX_B_OK(b_ok), .PWR_FAULT(pwr), .RELAY_READY(rdy), .RELAY_STATE(rs),
      .EQUIP_ON(eq), .PULSE_BUS(pb), .CMD_VERIFY(vfy), .MSG_ABORT(abt), .CMD_PENDING(pend));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // note an applied command and update the relay and power model
   task automatic expect_cmd(input logic [4:0] ch, input logic s);
      gcd_note_t n;
      exp_rs[ch-5'h01] = s;
      if (!DMASK[ch-5'h01]) exp_eq[ch-5'h01] = s;
      if (ch == `GCD_EXEC_CH_A || ch == `GCD_EXEC_CH_B)
         exp_eq = (exp_eq & ~DMASK) | (exp_rs & DMASK);
      n.abt = 1'b0;
      n.rs = exp_rs;
      notes.push_back(n);
   endtask
   task automatic expect_abort();
      gcd_note_t n;
      n.abt = 1'b1;
      n.rs = exp_rs;
      notes.push_back(n);
   endtask
   task automatic go(input logic [2:0] v, input logic [2:0] y, input logic [4:0] ch,
                     input logic s, input int n);
      gcd_uplink_i.send({v, y, ch, s}, n);
   endtask
   // bounded wait for all notes to be matched
   task automatic drain(input string nm);
      for (int i = 0; i < 3000 && notes.size() != 0; i++) @(posedge CLK);
      repeat (3) @(posedge CLK);
      chk("notes left", 24'h00_0000, 24'(notes.size()));
      chk("relays", exp_rs, rs);
      chk("equipment", exp_eq, eq);
      $display("test %s done", nm);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // watcher: each verify or abort takes the oldest note
   // ----------------------------------------------------------------
   always @(negedge CLK) begin
      if (RST_B && (vfy === 1'b1 || abt === 1'b1)) begin
         if (notes.size() == 0) chk("unexpected event", 24'h00_0000, 24'h00_0001);
         else begin
            chk("abort flag", 24'(notes[0].abt), 24'(abt));
            chk("relay state", notes[0].rs, rs);
            void'(notes.pop_front());
         end
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      expect_cmd(5'h0E, 1'b1);
      go(3'h5, 3'h3, 5'h0E, 1'b1, 12);
      drain("immediate");
      expect_cmd(5'h05, 1'b1);
      go(3'h5, 3'h3, 5'h05, 1'b1, 12);
      drain("deferred select");
      expect_cmd(5'h0F, 1'b0);
      go(3'h5, 3'h3, 5'h0F, 1'b0, 12);
      drain("execute");
      @(posedge CLK) a_ok <= 1'b0;
      b_ok <= 1'b1;
      expect_cmd(5'h0E, 1'b0);
      go(3'h5, 3'h3, 5'h0E, 1'b0, 12);
      expect_cmd(5'h11, 1'b1);
      go(3'h5, 3'h3, 5'h11, 1'b1, 12);
      @(posedge CLK) a_ok <= 1'b1;
      drain("second receiver");
      go(3'h4, 3'h3, 5'h0E, 1'b1, 3);
      go(3'h5, 3'h2, 5'h01, 1'b1, 6);
      drain("foreign address");
      expect_abort();
      go(3'h5, 3'h3, 5'h01, 1'b1, 8);
      expect_abort();
      fork
         go(3'h5, 3'h3, 5'h01, 1'b1, 3);
         begin
            while (gcd_uplink_i.q.size() != 2) @(posedge CLK);
            pwr <= 1'b1;
            @(posedge CLK) pwr <= 1'b0;
         end
      join
      drain("aborts");
      rc = 5'(seed[15:0] % 16'd24) + 5'h01;
      @(posedge CLK) rdy <= 1'b0;
      go(3'h5, 3'h3, 5'h16, 1'b1, 12);
      go(3'h5, 3'h3, 5'h12, 1'b1, 12);
      go(3'h5, 3'h3, 5'h19, 1'b1, 12);
      go(3'h5, 3'h3, rc, 1'b1, 12);
      expect_abort();
      go(3'h5, 3'h3, 5'h01, 1'b1, 12);
      chk("pending", 24'h00_0001, 24'(pend));
      expect_cmd(5'h16, 1'b1);
      expect_cmd(5'h12, 1'b1);
      expect_cmd(rc, 1'b1);
      @(posedge CLK) rdy <= 1'b1;
      drain("full queue");
      chk("pending", 24'h00_0000, 24'(pend));
      close_out();
   end
endmodule
`default_nettype wire

// file: gcd_defines.svh
// named constants for the ground command decoder
`ifndef GCD_DEFINES_SVH
`define GCD_DEFINES_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define GCD_CLK_KHZ        10000
`define GCD_SUBBIT_NS      10000
`define GCD_SUBBIT_CYC     ((`GCD_SUBBIT_NS * `GCD_CLK_KHZ) / 1000000)
`define GCD_TIMEOUT_MS     100
`define GCD_TIMEOUT_CYC    (`GCD_TIMEOUT_MS * `GCD_CLK_KHZ)
`define GCD_DIV_W          8
`define GCD_TMO_W          20

// ----------------------------------------------------------------------
// message layout
// ----------------------------------------------------------------------
`define GCD_MSG_BITS       12
`define GCD_SUBBITS        5
`define GCD_VEH_BITS       3
`define GCD_SYS_END        6
`define GCD_VEH_ADDR       3'h5
`define GCD_SYS_RTC        3'h3
`define GCD_CMD_W          6

// ----------------------------------------------------------------------
// sub-bit codes: before and after the vehicle address matched
// ----------------------------------------------------------------------
`define GCD_PRE_ONE        5'h16
`define GCD_PRE_ZERO       5'h09
`define GCD_POST_ONE       5'h1A
`define GCD_POST_ZERO      5'h05

// ----------------------------------------------------------------------
// relays and channels
// ----------------------------------------------------------------------
`define GCD_RELAYS         24
`define GCD_DEFER_MASK     24'h1C_1FFC
`define GCD_EXEC_CH_A      5'h0F
`define GCD_EXEC_CH_B      5'h12
`define GCD_FIFO_DEPTH     4

`endif

// file: gcd_fifo.sv
// small valid/ready fifo for decoded commands
`timescale 1ns/10ps
`default_nettype none
module gcd_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // storage words
   logic [AW-1:0]    wr_reg;        // write pointer
   logic [AW-1:0]    rd_reg;        // read pointer
   logic [AW:0]      cnt_reg;       // words held
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem[rd_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: gcd_pkg.sv
// types shared by the ground command decoder
package gcd_pkg;

   // message assembly states
   typedef enum logic [1:0] {
      GCD_HUNT = 2'b00,   // waiting for vehicle address
      GCD_BODY = 2'b01,   // vehicle matched, rest of message
      GCD_PUSH = 2'b10    // handing command to relay side
   } gcd_state_t;

endpackage

// file: gcd_uplink.sv
// ground transmitter model feeding both receivers
`timescale 1ns/10ps
`default_nettype none
`include "gcd_defines.svh"
module gcd_uplink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic a_ok,
   input wire logic rnd,
   output logic     a_info,
   output logic     a_ref,
   output logic     b_info,
   output logic     b_ref
);
   logic       q[$];  // sub-bits waiting to go out
   logic [6:0] cnt;   // sub-bit period divider
   logic       sub;   // sub-bit now on air
   logic       r;     // reference level, random each period
   // ----------------------------------------------------------------
   // one sub-bit per 100 clocks, idle zeros match no code
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 7'h00;
         sub <= 1'b0;
         r <= 1'b0;
      end else begin
         cnt <= (cnt == 7'd99) ? 7'h00 : cnt + 7'h01;
         if (cnt == 7'd99) begin
            r <= rnd;
            sub <= (q.size() != 0) ? q.pop_front() : 1'b0;
         end
      end
   end
   // in phase is one, inverted is zero
   assign a_ref = r;
   assign b_ref = r;
   assign b_info = sub ? r : ~r;
   // a failed receiver shows the inverted phase
   assign a_info = a_ok ? b_info : ~b_info;
   // queue n bits of a message, first bit first, five sub-bits each
   task automatic send(input logic [11:0] m, input int n);
      logic [4:0] c;
      for (int i = 0; i < n; i++) begin
         if (i < `GCD_VEH_BITS) c = m[11-i] ? `GCD_PRE_ONE : `GCD_PRE_ZERO;
         else c = m[11-i] ? `GCD_POST_ONE : `GCD_POST_ZERO;
         for (int j = 4; j >= 0; j--) q.push_back(c[j]);
      end
      while (q.size() != 0) @(posedge clk);
      repeat (600) @(posedge clk);
   endtask
endmodule
`default_nettype wire
